// >>> rtl/frpdc_host.v
// Host controller driving a boot-block flash through its reset,
// chip enable, write enable, output enable and data pins.
// Assumes the flash is asynchronous; data from it is synchronised.
//
// Overview of operation
// - After reset release the host waits the reset exit access time before reading.
// - The host begins a fresh chip-enable cycle before trusting read data.
// - The host writes only with both chip enable and write enable low.
// - While a program or erase is pending the host holds reads in array mode; it never writes read-array itself.
// - The flash reset pin follows the system reset of the processor.
`timescale 1ns/1ps
`include "frpdc_map.vh"
module frpdc_host #(
	parameter DW = 8
)(
	input  wire          clk_i,
	input  wire          rst_b_i,
	input  wire          pdown_req_i,
	input  wire          wr_req_i,
	input  wire          pair_i,
	input  wire [DW-1:0] cmd1_i,
	input  wire [DW-1:0] cmd2_i,
	input  wire          rd_req_i,
	input  wire          busy_op_i,
	input  wire [DW-1:0] dq_in_i,
	output reg           reset_powerdown_n_o,
	output reg           ce_n_o,
	output reg           we_n_o,
	output reg           oe_n_o,
	output reg  [DW-1:0] dq_out_o,
	output reg           dq_oe_o,
	output reg           ready_o,
	output reg           rd_valid_o,
	output reg  [DW-1:0] rd_data_o,
	output reg           array_mode_o,
	output reg           data_lost_o,
	output reg           op_done_o
);

localparam [31:0] EXIT_FULL = (`FRPDC_EXIT_ACCESS_NS
	+ `FRPDC_CLK_PERIOD_NS - 1) / `FRPDC_CLK_PERIOD_NS;
localparam [31:0] HOLD_FULL = (`FRPDC_LOW_HOLD_NS
	+ `FRPDC_CLK_PERIOD_NS - 1) / `FRPDC_CLK_PERIOD_NS;
localparam [31:0] WR_FULL   = (`FRPDC_WR_PULSE_NS
	+ `FRPDC_CLK_PERIOD_NS - 1) / `FRPDC_CLK_PERIOD_NS;
localparam [15:0] EXIT_CYC  = EXIT_FULL[15:0];
localparam [15:0] HOLD_CYC  = HOLD_FULL[15:0];
localparam [15:0] WR_CYC    = WR_FULL[15:0];

reg  [2:0]    state;
reg           second;
reg           op_pending;
reg  [DW-1:0] dq_s1;
reg  [DW-1:0] dq_s2;
reg           tload;
reg  [15:0]   tcount;
wire          tdone;

// ----------------------------------------------------------------
// Wait timer
// ----------------------------------------------------------------
frpdc_timer #(
	.WIDTH   (16)
) u_timer (
	.clk_i   (clk_i),
	.rst_b_i (rst_b_i),
	.load_i  (tload),
	.count_i (tcount),
	.done_o  (tdone)
);

// ----------------------------------------------------------------
// Data synchroniser
// ----------------------------------------------------------------
always @(posedge clk_i or negedge rst_b_i)
begin
	if (!rst_b_i)
	begin
		dq_s1 <= {DW{1'b0}};
		dq_s2 <= {DW{1'b0}};
	end
	else
	begin
		dq_s1 <= dq_in_i;
		dq_s2 <= dq_s1;
	end
end

// ----------------------------------------------------------------
// Sequencer
// ----------------------------------------------------------------
always @(posedge clk_i or negedge rst_b_i)
begin
	if (!rst_b_i)
	begin
		state               <= `FRPDC_ST_RESET;
		reset_powerdown_n_o <= 1'b0;
		ce_n_o              <= 1'b1;
		we_n_o              <= 1'b1;
		oe_n_o              <= 1'b1;
		dq_out_o            <= {DW{1'b0}};
		dq_oe_o             <= 1'b0;
		ready_o             <= 1'b0;
		rd_valid_o          <= 1'b0;
		rd_data_o           <= {DW{1'b0}};
		array_mode_o        <= 1'b1;
		data_lost_o         <= 1'b0;
		op_done_o           <= 1'b0;
		second              <= 1'b0;
		op_pending          <= 1'b0;
		tload               <= 1'b1;
		tcount              <= HOLD_CYC;
	end
	else
	begin
		tload      <= 1'b0;
		rd_valid_o <= 1'b0;
		op_done_o  <= 1'b0;
		case (state)
		`FRPDC_ST_RESET:
		begin
			if (tdone && !tload && !pdown_req_i)
			begin
				reset_powerdown_n_o <= 1'b1;
				tload               <= 1'b1;
				tcount              <= EXIT_CYC;
				state               <= `FRPDC_ST_EXIT;
			end
		end
		`FRPDC_ST_EXIT:
		begin
			if (tdone && !tload)
			begin
				array_mode_o <= 1'b1;
				ready_o      <= 1'b1;
				state        <= `FRPDC_ST_IDLE;
			end
		end
		`FRPDC_ST_IDLE:
		begin
			if (op_pending && !busy_op_i)
			begin
				op_pending <= 1'b0;
				op_done_o  <= 1'b1;
			end
			if (pdown_req_i)
			begin
				if (op_pending && busy_op_i)
					data_lost_o <= 1'b1;
				op_pending          <= 1'b0;
				reset_powerdown_n_o <= 1'b0;
				ready_o             <= 1'b0;
				tload               <= 1'b1;
				tcount              <= HOLD_CYC;
				state               <= `FRPDC_ST_PDOWN;
			end
			else if (wr_req_i)
			begin
				ready_o  <= 1'b0;
				second   <= 1'b0;
				dq_out_o <= cmd1_i;
				dq_oe_o  <= 1'b1;
				ce_n_o   <= 1'b0;
				we_n_o   <= 1'b0;
				tload    <= 1'b1;
				tcount   <= WR_CYC;
				state    <= `FRPDC_ST_WRITE;
				array_mode_o <= (cmd1_i == `FRPDC_CMD_READ_ARRAY)
					&& !pair_i;
				if (pair_i)
					op_pending <= 1'b1;
			end
			else if (rd_req_i && !(op_pending && array_mode_o))
			begin
				ready_o <= 1'b0;
				ce_n_o  <= 1'b0;
				oe_n_o  <= 1'b0;
				tload   <= 1'b1;
				tcount  <= EXIT_CYC;
				state   <= `FRPDC_ST_READ;
			end
		end
		`FRPDC_ST_WRITE:
		begin
			if (tdone && !tload)
			begin
				we_n_o <= 1'b1;
				ce_n_o <= 1'b1;
				state  <= `FRPDC_ST_GAP;
			end
		end
		`FRPDC_ST_GAP:
		begin
			dq_oe_o <= 1'b0;
			if (pair_i && !second)
			begin
				second   <= 1'b1;
				dq_out_o <= cmd2_i;
				dq_oe_o  <= 1'b1;
				ce_n_o   <= 1'b0;
				we_n_o   <= 1'b0;
				tload    <= 1'b1;
				tcount   <= WR_CYC;
				state    <= `FRPDC_ST_WRITE;
			end
			else
			begin
				ready_o <= 1'b1;
				state   <= `FRPDC_ST_IDLE;
			end
		end
		`FRPDC_ST_READ:
		begin
			if (tdone && !tload)
			begin
				rd_data_o  <= dq_s2;
				rd_valid_o <= 1'b1;
				ce_n_o     <= 1'b1;
				oe_n_o     <= 1'b1;
				ready_o    <= 1'b1;
				state      <= `FRPDC_ST_IDLE;
			end
		end
		`FRPDC_ST_PDOWN:
		begin
			array_mode_o <= 1'b1;
			if (tdone && !tload && !pdown_req_i)
			begin
				reset_powerdown_n_o <= 1'b1;
				tload               <= 1'b1;
				tcount              <= EXIT_CYC;
				state               <= `FRPDC_ST_EXIT;
			end
		end
		default:
		begin
			state <= `FRPDC_ST_RESET;
		end
		endcase
	end
end

endmodule // frpdc_host

// >>> rtl/frpdc_map.vh
// Constants for the flash reset and power-down host controller.
// Assumes a 50 MHz clock; timing figures are in nanoseconds.
`ifndef FRPDC_MAP_VH
`define FRPDC_MAP_VH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define FRPDC_CLK_PERIOD_NS     20
`define FRPDC_EXIT_ACCESS_NS    300
`define FRPDC_LOW_HOLD_NS       100
`define FRPDC_WR_PULSE_NS       60

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define FRPDC_CMD_READ_ARRAY    8'hFF
`define FRPDC_CMD_READ_STATUS   8'h70
`define FRPDC_CMD_CLEAR_STATUS  8'h50

// ----------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------
`define FRPDC_SR_READY_BIT      7

// ----------------------------------------------------------------
// Controller states
// ----------------------------------------------------------------
`define FRPDC_ST_RESET          3'h0
`define FRPDC_ST_EXIT           3'h1
`define FRPDC_ST_IDLE           3'h2
`define FRPDC_ST_WRITE          3'h3
`define FRPDC_ST_GAP            3'h4
`define FRPDC_ST_READ           3'h5
`define FRPDC_ST_PDOWN          3'h6

`endif

// >>> rtl/frpdc_timer.v
// Down counter used for all waits of the host controller.
// Assumes load and start come from logic on the same clock.
`timescale 1ns/1ps
module frpdc_timer #(
	parameter WIDTH = 16
)(
	input  wire             clk_i,
	input  wire             rst_b_i,
	input  wire             load_i,
	input  wire [WIDTH-1:0] count_i,
	output reg              done_o
);

reg [WIDTH-1:0] count;

// ----------------------------------------------------------------
// Counter
// ----------------------------------------------------------------
always @(posedge clk_i or negedge rst_b_i)
begin
	if (!rst_b_i)
	begin
		count  <= {WIDTH{1'b0}};
		done_o <= 1'b0;
	end
	else if (load_i)
	begin
		count  <= count_i;
		done_o <= 1'b0;
	end
	else if (count != {WIDTH{1'b0}})
	begin
		count  <= count - {{(WIDTH-1){1'b0}}, 1'b1};
		done_o <= (count == {{(WIDTH-1){1'b0}}, 1'b1});
	end
	else
	begin
		done_o <= 1'b1;
	end
end

endmodule // frpdc_timer

// >>> sim/frpdc_host_asserts.sv
// Checker for the flash reset and power-down host controller.
// Assumes it is bound to frpdc_host and sees only its ports.
`timescale 1ns/1ps
module frpdc_chk (
	input wire logic clk_i, rst_b_i, pdown_req_i, reset_powerdown_n_o,
	input wire logic ce_n_o, we_n_o, oe_n_o, dq_oe_o, ready_o,
	input wire logic array_mode_o, data_lost_o, rd_valid_o, op_done_o
);
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	a_rst_hold: assert property ($rose(rst_b_i) |->
		!reset_powerdown_n_o [*4]) else $error("reset pin released early");
	a_write_both_low: assert property (!we_n_o |-> !ce_n_o)
		else $error("write enable low without chip enable");
	a_pin_idle_rst: assert property (!reset_powerdown_n_o |->
		ce_n_o && we_n_o && !dq_oe_o) else $error("pins active in reset");
	a_exit_wait: assert property ($rose(reset_powerdown_n_o) |->
		(!ready_o && oe_n_o) [*8]) else $error("access before exit time");
	a_we_drive: assert property (!we_n_o |-> dq_oe_o && oe_n_o)
		else $error("write without data drive");
	a_pdown_take: assert property (pdown_req_i && ready_o |->
		##[1:8] !reset_powerdown_n_o) else $error("power-down not entered");
	a_lost_sticky: assert property (data_lost_o |=> data_lost_o)
		else $error("lost flag dropped");
	a_array_exit: assert property ($rose(reset_powerdown_n_o) |->
		array_mode_o) else $error("not in array mode on exit");
	c_read: cover property (rd_valid_o);
	c_done: cover property (op_done_o);
	c_lost: cover property ($rose(data_lost_o));
endmodule // frpdc_chk
bind frpdc_host frpdc_chk u_chk (.clk_i(clk_i), .rst_b_i(rst_b_i),
	.pdown_req_i(pdown_req_i), .reset_powerdown_n_o(reset_powerdown_n_o),
	.ce_n_o(ce_n_o), .we_n_o(we_n_o), .oe_n_o(oe_n_o), .dq_oe_o(dq_oe_o),
	.ready_o(ready_o), .array_mode_o(array_mode_o),
	.data_lost_o(data_lost_o), .rd_valid_o(rd_valid_o),
	.op_done_o(op_done_o));

// >>> sim/frpdc_flash_model.sv
// Behavioural flash device seen through its control and data pins.
// Assumes the bench supplies the array byte it returns.
`timescale 1ns/1ps
module frpdc_flash_model (
	input  wire logic       rpd_n_i, ce_n_i, we_n_i, oe_n_i, dq_oe_i,
	input  wire logic [7:0] dq_i, arr_i,
	output logic      [7:0] dq_o,
	output int              nwr,
	output logic      [7:0] last
);
	logic [7:0] flip = 8'h0F;
	logic       array_md = 1'b1;
	wire        wr_act = rpd_n_i && !ce_n_i && !we_n_i;
	always #7 flip = ~flip;
	// Drives a toggling pattern unless selected, reading and out of reset
	assign dq_o = (rpd_n_i && !ce_n_i && !oe_n_i) ?
		(array_md ? arr_i : 8'h80) : flip;
	always @(negedge rpd_n_i) array_md = 1'b1;
	// Write lands when the first of chip or write enable rises
	always @(negedge wr_act)
		if (rpd_n_i && dq_oe_i)
		begin
			nwr++;
			last = dq_i;
			array_md = (dq_i == 8'hFF);
		end
	initial nwr = 0;
endmodule // frpdc_flash_model

// >>> sim/tb_flash_reset_powerdown_control.sv
// Self-checking bench for the flash reset and power-down controller.
// Assumes the flash model and the bound checker are compiled first.
`timescale 1ns/1ps
module tb_flash_reset_powerdown_control;
	logic clk_i = 0, rst_b_i = 0, pdown_req_i = 0, wr_req_i = 0;
	logic pair_i = 0, rd_req_i = 0, busy_op_i = 0;
	logic [7:0] cmd1_i = 0, cmd2_i = 0, dq_in_i, dq_out_o, rd_data_o, arr;
	logic [7:0] last, c1, c2;
	logic rpd_n, ce_n, we_n, oe_n, dq_oe, ready_o, rd_valid_o;
	logic array_mode_o, data_lost_o, op_done_o, seen;
	int miscompares = 0, n_tests = 0, nwr, seed = 31228, k;
	logic [7:0] wq[$];
	always #10 clk_i = ~clk_i;
	frpdc_host dut (.clk_i(clk_i), .rst_b_i(rst_b_i),
		.pdown_req_i(pdown_req_i), .wr_req_i(wr_req_i), .pair_i(pair_i),
		.cmd1_i(cmd1_i), .cmd2_i(cmd2_i), .rd_req_i(rd_req_i),
		.busy_op_i(busy_op_i), .dq_in_i(dq_in_i),
		.reset_powerdown_n_o(rpd_n), .ce_n_o(ce_n), .we_n_o(we_n),
		.oe_n_o(oe_n), .dq_out_o(dq_out_o), .dq_oe_o(dq_oe),
		.ready_o(ready_o), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o),
		.array_mode_o(array_mode_o), .data_lost_o(data_lost_o),
		.op_done_o(op_done_o));
	frpdc_flash_model u_flash (.rpd_n_i(rpd_n), .ce_n_i(ce_n),
		.we_n_i(we_n), .oe_n_i(oe_n), .dq_oe_i(dq_oe), .dq_i(dq_out_o),
		.arr_i(arr), .dq_o(dq_in_i), .nwr(nwr), .last(last));
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task chk(input string nm, input logic [7:0] got, exp);
		n_tests++;
		if (got !== exp)
		begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task wrdy;
		@(negedge clk_i);
		for (k = 0; k < 300 && ready_o !== 1'b1; k++)
			@(negedge clk_i);
		if (ready_o !== 1'b1)
			miscompares++;
	endtask
	task wr(input logic p, input logic [7:0] a, b);
		@(posedge clk_i);
		pair_i   <= p;
		cmd1_i   <= a;
		cmd2_i   <= b;
		wr_req_i <= 1;
		@(posedge clk_i);
		wr_req_i <= 0;
		wq.push_back(a);
		if (p)
			wq.push_back(b);
		wrdy;
	endtask
	task rd;
		@(posedge clk_i);
		rd_req_i <= 1;
		@(posedge clk_i);
		rd_req_i <= 0;
		for (k = 0; k < 60 && rd_valid_o !== 1'b1; k++)
			@(negedge clk_i);
		chk("rd_valid", rd_valid_o, 1);
		chk("rd_data", rd_data_o, arr);
		wrdy;
	endtask
	task complete_run;
		$display("tests %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial
	begin
		#200000 miscompares++;
		complete_run;
	end
	initial
	begin
		arr = $random(seed);
		repeat (4) @(posedge clk_i);
		rst_b_i <= 1;
		wrdy;
		chk("array_mode", array_mode_o, 1);
		chk("rpd_pin", rpd_n, 1);
		repeat (2) rd;
		c1 = $random(seed);
		c1[0] = 0;
		wr(0, c1, 8'h00);
		chk("nwr", nwr, wq.size());
		chk("last", last, wq[$]);
		chk("array_mode", array_mode_o, 0);
		wr(0, 8'hFF, 8'h00);
		chk("array_mode", array_mode_o, 1);
		arr = $random(seed);
		rd;
		c1 = $random(seed);
		c2 = $random(seed);
		@(posedge clk_i) busy_op_i <= 1;
		wr(1, c1, c2);
		chk("nwr", nwr, wq.size());
		chk("last", last, wq[$]);
		@(posedge clk_i) busy_op_i <= 0;
		seen = 0;
		repeat (20) @(negedge clk_i) seen |= op_done_o;
		chk("op_done", seen, 1);
		@(posedge clk_i) busy_op_i <= 1;
		wr(1, $random(seed), $random(seed));
		@(posedge clk_i) pdown_req_i <= 1;
		repeat (20) @(negedge clk_i);
		chk("rpd_pin", rpd_n, 0);
		chk("data_lost", data_lost_o, 1);
		@(posedge clk_i)
		begin
			pdown_req_i <= 0;
			busy_op_i   <= 0;
		end
		wrdy;
		chk("array_mode", array_mode_o, 1);
		// System reset cuts a write pulse short
		@(posedge clk_i);
		pair_i   <= 0;
		cmd1_i   <= 8'h00;
		wr_req_i <= 1;
		@(posedge clk_i);
		wr_req_i <= 0;
		repeat (2) @(posedge clk_i);
		rst_b_i <= 0;
		repeat (4) @(posedge clk_i);
		rst_b_i <= 1;
		@(negedge clk_i);
		chk("rpd_pin", rpd_n, 0);
		wrdy;
		chk("nwr", nwr, wq.size());
		chk("data_lost", data_lost_o, 0);
		chk("array_mode", array_mode_o, 1);
		rd;
		complete_run;
	end
endmodule // tb_flash_reset_powerdown_control
